// ---- core/exc_entry.sv ----
// Exception entry, preemption and stack frame writer
`timescale 1ns/1ps
module exc_entry
  import exc_entry_pkg::*;
#(
  parameter bit MAIN_EXT = 1'b1,
  parameter bit FP_EXT = 1'b1,
  parameter bit SEC_EXT = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Stack and vector memory master
  output logic mem_cyc_o,
  output logic mem_stb_o,
  output logic mem_we_o,
  output logic [3:0] mem_sel_o,
  output logic [31:0] mem_adr_o,
  output logic [31:0] mem_dat_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_dat_i,
  input wire logic vec_secure_i,
  input wire logic vec_sg_nsc_i,
  // Core context
  input wire logic [12:0][31:0] regs_i,
  input wire logic [31:0] lr_i,
  input wire logic [31:0] sp_i,
  input wire logic [31:0] psr_i,
  input wire logic [8:0] exception_number_status_i,
  input wire logic spsel_i,
  input wire logic sfpa_i,
  input wire logic fpca_i,
  input wire logic [31:0] cur_pc_i,
  input wire logic [31:0] next_pc_i,
  input wire logic [7:0] cur_prio_i,
  output logic [4:0] fp_idx_o,
  input wire logic [31:0] fp_dat_i,
  // Exception sources
  input wire logic [NUM_EXC-1:0] exc_set_i,
  input wire logic [NUM_EXC-1:0] exc_sync_i,
  input wire logic [NUM_EXC-1:0] exc_secure_i,
  input wire logic [NUM_EXC-1:0][7:0] exc_prio_i,
  // Function return checks
  input wire logic fnc_chk_i,
  input wire logic [31:0] pc_load_i,
  input wire logic [8:0] stacked_exception_number_status_i,
  input wire logic [31:0] stacked_ra_i,
  input wire logic ret_handler_i,
  // Entry results
  output logic [31:0] pc_o,
  output logic [31:0] lr_o,
  output logic [8:0] exception_number_status_o,
  output logic handler_mode_o,
  output logic thumb_o,
  output logic spsel_o,
  output logic entry_done_o,
  output logic busy_o
);

  state_t s, next_s;
  logic [NUM_EXC-1:0][7:0] eff_prio;
  logic [7:0] best_prio;
  logic [4:0] best_num, rel;
  logic [5:0] frame_words, base, ofs;
  logic [31:0] wdat;
  logic best_valid, preempt, is_fnc, chk_fail, bad_ra, wapp, vec_ok, wb_req;

  // Priority split pushes Non-secure priorities into the lower half
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXC; gi++) begin : g_prio
      assign eff_prio[gi] = (s.split && !exc_secure_i[gi]) ?
                            {1'b1, exc_prio_i[gi][7:1]} : exc_prio_i[gi];
    end
  endgenerate

  always_comb begin
    best_prio = 8'hFF;
    best_num = 5'h00;
    best_valid = 1'b0;
    for (int i = 0; i < NUM_EXC; i++) begin
      if (s.pending[i] && (!best_valid || eff_prio[i] < best_prio)) begin
        best_prio = eff_prio[i];
        best_num = 5'(i);
        best_valid = 1'b1;
      end
    end
  end

  assign preempt = best_valid && (best_prio < cur_prio_i);
  assign is_fnc = (pc_load_i[31:1] == FNC_RET_UPPER);
  assign chk_fail = (exception_number_status_i > 9'h001) || (!ret_handler_i && stacked_exception_number_status_i != 9'h000)
                    || (ret_handler_i && stacked_exception_number_status_i == 9'h000);
  assign bad_ra = !stacked_ra_i[0];
  assign wb_req = wb_cyc_i && wb_stb_i && !s.wb_ack;
  assign base = s.ext ? ADD_WORDS : 6'h00;
  assign rel = 5'(s.step - STEP_FP0);
  assign fp_idx_o = rel;
  assign vec_ok = !SEC_EXT || (exc_secure_i[s.num] == vec_secure_i)
                  || (!exc_secure_i[s.num] && vec_sg_nsc_i);

  // Word to push at the current step
  always_comb begin
    ofs = base + s.step;
    wdat = 32'h0000_0000;
    wapp = 1'b1;
    if (s.step < 6'h04) begin
      wdat = regs_i[s.step[1:0]];
    end else if (s.step == 6'h04) begin
      wdat = regs_i[12];
    end else if (s.step == 6'h05) begin
      wdat = lr_i;
    end else if (s.step == STEP_PSR) begin
      ofs = base + 6'h07;
      wdat = psr_i;
      wdat[PSR_SFPA_BIT] = sfpa_i;
      wdat[PSR_REALIGN_BIT] = s.pad;
    end else if (s.step == STEP_RA) begin
      ofs = base + 6'h06;
      wdat = s.ra;
    end else if (s.step <= STEP_FP_LAST) begin
      wdat = fp_dat_i;
      wapp = s.fp && !s.lazy_en;
    end else begin
      ofs = s.step - STEP_ADD0;
      wapp = s.ext;
      if (ofs == 6'h00) begin
        wdat = INTEGRITY_SIG;
      end else if (ofs == 6'h01) begin
        wdat = 32'h0000_0000;
      end else begin
        wdat = regs_i[ofs[3:0] + 4'h2];
      end
    end
  end

  always_comb begin
    next_s = s;
    next_s.co.done = 1'b0;
    frame_words = STATE_WORDS + (s.fp ? FP_WORDS : 6'h00) + (s.ext ? ADD_WORDS : 6'h00);
    // Register bus
    next_s.wb_ack = wb_req;
    if (wb_req) begin
      next_s.wb_dat = 32'h0000_0000;
      case (wb_adr_i)
        ADR_CTRL: begin
          next_s.wb_dat[CTRL_LAZY_BIT] = s.lazy_en;
          next_s.wb_dat[CTRL_SPLIT_BIT] = s.split;
          if (wb_we_i && wb_sel_i[0]) begin
            next_s.lazy_en = wb_dat_i[CTRL_LAZY_BIT];
            next_s.split = wb_dat_i[CTRL_SPLIT_BIT];
          end
        end
        ADR_STATUS: begin
          next_s.wb_dat[4:0] = s.faults;
          next_s.wb_dat[ST_LAZY_BIT] = s.lazy_act;
          next_s.wb_dat[ST_BUSY_BIT] = (s.st != ST_IDLE);
          if (wb_we_i && wb_sel_i[0]) begin
            next_s.faults = s.faults & ~wb_dat_i[4:0];
          end
          if (wb_we_i && wb_sel_i[1]) begin
            next_s.lazy_act = s.lazy_act & ~wb_dat_i[ST_LAZY_BIT];
          end
        end
        ADR_PEND: begin
          next_s.wb_dat = s.pending;
          if (wb_we_i) begin
            next_s.pending = s.pending | wb_dat_i;
          end
        end
        ADR_ACTIVE: begin
          next_s.wb_dat = s.active;
          if (wb_we_i) begin
            next_s.active = s.active & ~wb_dat_i;
          end
        end
        ADR_VTOR: begin
          next_s.wb_dat = s.vtor;
          if (wb_we_i) begin
            next_s.vtor = {wb_dat_i[31:7], 7'h00};
          end
        end
        ADR_FRAME_SP: next_s.wb_dat = s.frame_sp;
        ADR_FP_ADDR: next_s.wb_dat = s.fp_addr;
        default: next_s.wb_dat = 32'h0000_0000;
      endcase
    end
    // Hardware set is ORed in; bus writes to pending can only set bits, never clear them
    next_s.pending = next_s.pending | exc_set_i;
    if (fnc_chk_i && is_fnc && chk_fail) begin
      if (MAIN_EXT) begin
        next_s.faults[ST_BAD_RETURN] = 1'b1;
        next_s.pending[USAGE_FAULT_NUM] = 1'b1;
      end else begin
        next_s.faults[ST_HARD] = 1'b1;
        next_s.pending[HARD_FAULT_NUM] = 1'b1;
      end
    end
    if (fnc_chk_i && is_fnc && bad_ra) begin
      next_s.faults[ST_BAD_EXEC] = 1'b1;
      next_s.pending[USAGE_FAULT_NUM] = 1'b1;
    end
    // Entry sequence
    case (s.st)
      ST_IDLE: begin
        next_s.co.exception_number_status = exception_number_status_i;
        next_s.co.spsel = spsel_i;
        if (preempt) begin
          next_s.num = best_num;
          next_s.pad = sp_i[2];
          next_s.fp = FP_EXT && fpca_i;
          next_s.ext = SEC_EXT && !exc_secure_i[best_num];
          next_s.ra = (exc_sync_i[best_num] && best_num != SVCALL_NUM) ?
                      cur_pc_i : next_pc_i;
          next_s.ra[0] = 1'b0;
          next_s.st = ST_ALLOC;
        end
      end
      ST_ALLOC: begin
        next_s.frame_sp = {sp_i[31:3], 3'b000} - {24'h000000, frame_words, 2'b00};
        if (s.fp && s.lazy_en) begin
          next_s.fp_addr = next_s.frame_sp + {24'h000000, base, 2'b00}
                           + {24'h000000, FP_OFS_BYTES};
          next_s.lazy_act = 1'b1;
        end
        next_s.step = 6'h00;
        next_s.st = ST_PUSH;
      end
      ST_PUSH: begin
        if (s.busy) begin
          next_s.busy = !mem_ack_i;
        end else if (s.step > STEP_LAST) begin
          next_s.st = ST_LR;
        end else begin
          if (wapp) begin
            next_s.busy = 1'b1;
            next_s.adr = s.frame_sp + {24'h000000, ofs, 2'b00};
            next_s.dat = wdat;
          end
          next_s.step = s.step + 6'h01;
        end
      end
      ST_LR: begin
        next_s.co.lr = EXC_RET_BASE | {25'h0, exc_secure_i[s.num], !s.ext, !s.fp,
                       (s.co.exception_number_status == 9'h000), spsel_i, 2'b01};
        next_s.st = ST_TAKE;
      end
      ST_TAKE: begin
        if (best_valid && best_prio < eff_prio[s.num]) begin
          next_s.num = best_num;
        end
        next_s.co.exception_number_status = {4'h0, next_s.num};
        next_s.co.spsel = 1'b0;
        next_s.pending[next_s.num] = exc_set_i[next_s.num];
        next_s.active[next_s.num] = 1'b1;
        next_s.busy = 1'b1;
        next_s.adr = s.vtor + {25'h0, next_s.num, 2'b00};
        next_s.st = ST_VEC;
      end
      ST_VEC: begin
        if (mem_ack_i) begin
          next_s.busy = 1'b0;
          next_s.st = ST_IDLE;
          if (vec_ok) begin
            next_s.co.thumb = mem_dat_i[0];
            next_s.co.pc = mem_dat_i;
            next_s.co.done = 1'b1;
          end else begin
            next_s.faults[exc_secure_i[s.num] ? ST_BAD_TRAN : ST_BAD_ENTRY] = 1'b1;
            next_s.pending[SECURE_FAULT_NUM] = 1'b1;
          end
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.vtor <= VTOR_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack_o = s.wb_ack;
  assign wb_dat_o = s.wb_dat;
  assign mem_cyc_o = s.busy;
  assign mem_stb_o = s.busy;
  assign mem_we_o = (s.st != ST_VEC);
  assign mem_sel_o = 4'hF;
  assign mem_adr_o = s.adr;
  assign mem_dat_o = s.dat;
  assign pc_o = s.co.pc;
  assign lr_o = s.co.lr;
  assign exception_number_status_o = s.co.exception_number_status;
  assign handler_mode_o = (s.co.exception_number_status != 9'h000);
  assign thumb_o = s.co.thumb;
  assign spsel_o = s.co.spsel;
  assign entry_done_o = s.co.done;
  assign busy_o = (s.st != ST_IDLE);

  AST_FNC_FAULT: assert property (@(posedge clk_i) disable iff (rst_i)
    fnc_chk_i && is_fnc && chk_fail |=> (MAIN_EXT ? s.faults[ST_BAD_RETURN] : s.faults[ST_HARD]))
    else $error("function return fault not recorded");
  AST_RA_STATE: assert property (@(posedge clk_i) disable iff (rst_i)
    fnc_chk_i && is_fnc && !stacked_ra_i[0] |=> s.faults[ST_BAD_EXEC] && s.pending[USAGE_FAULT_NUM])
    else $error("bad exec state fault missing");
  AST_PREEMPT: assert property (@(posedge clk_i) disable iff (rst_i)
    s.st == ST_IDLE && next_s.st == ST_ALLOC |-> best_prio < cur_prio_i)
    else $error("entry started without priority win");
  AST_LR_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
    s.st == ST_LR |=> s.st == ST_TAKE ##1 lr_o[31:7] == EXC_RET_BASE[31:7])
    else $error("link value not set before take");
  AST_SPSEL: assert property (@(posedge clk_i) disable iff (rst_i)
    s.st == ST_TAKE |=> !spsel_o && handler_mode_o && s.active[s.num])
    else $error("stack select or active not updated");
  AST_VEC_PC: assert property (@(posedge clk_i) disable iff (rst_i)
    s.st == ST_VEC && mem_ack_i && vec_ok |=> pc_o == $past(mem_dat_i) && thumb_o == $past(mem_dat_i[0]))
    else $error("vector not loaded");
  AST_IN_FRAME: assert property (@(posedge clk_i) disable iff (rst_i)
    s.busy && s.st == ST_PUSH |-> s.adr >= s.frame_sp && s.adr[1:0] == 2'b00)
    else $error("push outside frame");
  AST_RA_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    s.st == ST_ALLOC |-> !s.ra[0])
    else $error("return address bit zero set");
  AST_REALIGN: assert property (@(posedge clk_i) disable iff (rst_i)
    s.st == ST_PUSH && !s.busy && s.step == STEP_PSR |=> s.dat[PSR_REALIGN_BIT] == s.pad)
    else $error("realign flag wrong");
endmodule : exc_entry

// ---- core/exc_entry_pkg.sv ----
// Constants and types for the exception entry and stacking block
package exc_entry_pkg;
  localparam int NUM_EXC = 32;
  localparam logic [4:0] HARD_FAULT_NUM = 5'h03;
  localparam logic [4:0] USAGE_FAULT_NUM = 5'h06;
  localparam logic [4:0] SECURE_FAULT_NUM = 5'h07;
  localparam logic [4:0] SVCALL_NUM = 5'h0B;
  // Register word addresses (byte address bits [7:0])
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_PEND = 8'h08;
  localparam logic [7:0] ADR_ACTIVE = 8'h0C;
  localparam logic [7:0] ADR_VTOR = 8'h10;
  localparam logic [7:0] ADR_FRAME_SP = 8'h14;
  localparam logic [7:0] ADR_FP_ADDR = 8'h18;
  // Field positions
  localparam int CTRL_LAZY_BIT = 0;
  localparam int CTRL_SPLIT_BIT = 1;
  localparam int ST_BAD_RETURN = 0;
  localparam int ST_BAD_EXEC = 1;
  localparam int ST_BAD_ENTRY = 2;
  localparam int ST_BAD_TRAN = 3;
  localparam int ST_HARD = 4;
  localparam int ST_LAZY_BIT = 8;
  localparam int ST_BUSY_BIT = 9;
  localparam int PSR_REALIGN_BIT = 9;
  localparam int PSR_SFPA_BIT = 20;
  localparam logic [31:0] VTOR_RESET = 32'h0000_0000;
  // Frame layout in words and push steps, FP area offset in bytes
  localparam logic [5:0] STATE_WORDS = 6'h08;
  localparam logic [5:0] FP_WORDS = 6'h12;
  localparam logic [5:0] ADD_WORDS = 6'h0A;
  localparam logic [5:0] STEP_PSR = 6'h06;
  localparam logic [5:0] STEP_RA = 6'h07;
  localparam logic [5:0] STEP_FP0 = 6'h08;
  localparam logic [5:0] STEP_FP_LAST = 6'h18;
  localparam logic [5:0] STEP_ADD0 = 6'h19;
  localparam logic [5:0] STEP_LAST = 6'h22;
  localparam logic [7:0] FP_OFS_BYTES = 8'h20;
  // Arbitrary function-return pattern and integrity signature
  localparam logic [30:0] FNC_RET_UPPER = 31'h7F7F_FFFF;
  localparam logic [31:0] INTEGRITY_SIG = 32'h5AA5_0F0E;
  localparam logic [31:0] EXC_RET_BASE = 32'hFFFF_FF80;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ALLOC = 3'h1,
    ST_PUSH = 3'h3,
    ST_LR = 3'h2,
    ST_TAKE = 3'h6,
    ST_VEC = 3'h7
  } phase_t;

  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] lr;
    logic [8:0] exception_number_status;
    logic thumb;
    logic spsel;
    logic done;
  } core_out_t;

  typedef struct packed {
    phase_t st;
    logic [4:0] num;
    logic [NUM_EXC-1:0] pending;
    logic [NUM_EXC-1:0] active;
    logic lazy_en;
    logic split;
    logic [4:0] faults;
    logic lazy_act;
    logic [5:0] step;
    logic busy;
    logic [31:0] adr;
    logic [31:0] dat;
    logic [31:0] frame_sp;
    logic pad;
    logic ext;
    logic fp;
    logic [31:0] ra;
    logic [31:0] vtor;
    logic [31:0] fp_addr;
    core_out_t co;
    logic wb_ack;
    logic [31:0] wb_dat;
  } state_t;
endpackage : exc_entry_pkg

// ---- bench/stack_mem_model.sv ----
// Stack and vector memory answering the entry block's master port
`timescale 1ns/1ps
module stack_mem_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus from the entry block
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  // Answer delay in cycles
  input wire logic [3:0] wait_i,
  // Answer
  output logic ack_o,
  output logic [31:0] dat_o
);
  logic [31:0] mem [0:255];
  logic [3:0] cnt;

  // Vector table words, odd entries carry the Thumb bit
  initial begin
    for (int i = 0; i < 256; i++)
      mem[i] = 32'h1000 + 32'(i << 8) + 32'(i & 1);
  end

  // Ack after wait_i idle cycles, drop it the cycle after
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
      cnt <= 4'h0;
    end else if (cyc_i && stb_i && !ack_o && cnt == wait_i) begin
      ack_o <= 1'b1;
      cnt <= 4'h0;
      if (we_i)
        mem[adr_i[9:2]] <= dat_i;
      else
        dat_o <= mem[adr_i[9:2]];
    end else begin
      ack_o <= 1'b0;
      cnt <= (cyc_i && stb_i && !ack_o) ? cnt + 4'h1 : 4'h0;
      dat_o <= ~dat_o;
    end
  end
endmodule : stack_mem_model

// ---- bench/test_exception_entry_stacking.sv ----
// Self-checking bench for exception entry and stacking
`timescale 1ns/1ps
module test_exception_entry_stacking import exc_entry_pkg::*; ;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mem_cyc_o, mem_stb_o, mem_we_o;
  logic mem_ack_i, vec_secure_i, vec_sg_nsc_i, spsel_i, sfpa_i, fpca_i, fnc_chk_i;
  logic ret_handler_i, handler_mode_o, thumb_o, spsel_o, entry_done_o, busy_o;
  logic [7:0] wb_adr_i, cur_prio_i;
  logic [3:0] wb_sel_i, mem_wait, mem_sel_o;
  logic [31:0] wb_dat_i, wb_dat_o, mem_adr_o, mem_dat_o, mem_dat_i, lr_i, sp_i, psr_i;
  logic [31:0] cur_pc_i, next_pc_i, fp_dat_i, pc_load_i, stacked_ra_i, pc_o, lr_o;
  logic [12:0][31:0] regs_i;
  logic [8:0] exception_number_status_i, stacked_exception_number_status_i, exception_number_status_o;
  logic [4:0] fp_idx_o;
  logic [NUM_EXC-1:0] exc_set_i, exc_sync_i, exc_secure_i;
  logic [NUM_EXC-1:0][7:0] exc_prio_i;
  logic [31:0] wlog [$];
  int err_total, checks;

  exc_entry u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_ack_o, .wb_dat_o, .mem_cyc_o, .mem_stb_o, .mem_we_o, .mem_sel_o,
    .mem_adr_o, .mem_dat_o, .mem_ack_i, .mem_dat_i, .vec_secure_i, .vec_sg_nsc_i, .regs_i,
    .lr_i, .sp_i, .psr_i, .exception_number_status_i, .spsel_i, .sfpa_i, .fpca_i, .cur_pc_i, .next_pc_i,
    .cur_prio_i, .fp_idx_o, .fp_dat_i, .exc_set_i, .exc_sync_i, .exc_secure_i, .exc_prio_i,
    .fnc_chk_i, .pc_load_i, .stacked_exception_number_status_i, .stacked_ra_i, .ret_handler_i, .pc_o, .lr_o,
    .exception_number_status_o, .handler_mode_o, .thumb_o, .spsel_o, .entry_done_o, .busy_o);

  stack_mem_model u_mem (.clk_i, .rst_i, .cyc_i(mem_cyc_o), .stb_i(mem_stb_o),
    .we_i(mem_we_o), .adr_i(mem_adr_o), .dat_i(mem_dat_o), .wait_i(mem_wait),
    .ack_o(mem_ack_i), .dat_o(mem_dat_i));

  // FP register file answer
  assign fp_dat_i = {27'h7800000, fp_idx_o};

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Push addresses in bus order
  always @(posedge clk_i) begin
    if (mem_cyc_o && mem_stb_o && mem_ack_i && mem_we_o)
      wlog.push_back(mem_adr_o);
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    chk("bus ack", 32'h1, 32'(wb_ack_o));
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask : rd

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (entry_done_o !== 1'b1 && n < 400);
    chk("entry done", 32'h1, 32'(entry_done_o));
  endtask : wait_done

  task automatic enter(input int num, input logic [7:0] pr, input logic sy,
      input logic [31:0] sp, input logic sf, input logic fc, input int nwr,
      output logic [31:0] base);
    logic [31:0] v, q;
    logic [31:0] ex [8];
    base = {sp[31:3], 3'h0} - (fc ? 32'h68 : 32'h20);
    v = 32'h1000 + 32'(num << 8) + 32'(num & 1);
    ex = '{regs_i[0], regs_i[1], regs_i[2], regs_i[3], regs_i[12], lr_i,
      (sy && num != SVCALL_NUM) ? {cur_pc_i[31:1], 1'b0} : {next_pc_i[31:1], 1'b0},
      {11'h200, sf, 10'h0, sp[2], exception_number_status_i}};
    wlog.delete();
    sp_i <= sp;
    sfpa_i <= sf;
    fpca_i <= fc;
    psr_i <= {11'h200, ~sf, 10'h0, ~sp[2], exception_number_status_i};
    exc_prio_i[num] <= pr;
    exc_sync_i[num] <= sy;
    exc_set_i[num] <= 1'b1;
    @(posedge clk_i);
    exc_set_i <= '0;
    wait_done();
    chk("byte lanes", 32'hF, 32'(mem_sel_o));
    chk("exception_number_status", 32'(num), 32'(exception_number_status_o));
    chk("handler mode", 32'h1, 32'(handler_mode_o));
    chk("stack select", 32'h0, 32'(spsel_o));
    chk("thumb", 32'(v[0]), 32'(thumb_o));
    chk("pc", {v[31:1], 1'b0}, {pc_o[31:1], 1'b0});
    chk("link", {EXC_RET_BASE[31:7], 1'b0, 1'b1, ~fc, exception_number_status_i == 9'h0, spsel_i, 2'h1},
      lr_o);
    chk("words written", 32'(nwr), 32'(wlog.size()));
    for (int k = 0; k < nwr; k++)
      chk("push adr", base + (k == 6 ? 32'h1C : k == 7 ? 32'h18 : 32'(4 * k)), wlog[k]);
    for (int k = 0; k < 8; k++)
      chk("state word", ex[k], u_mem.mem[base[9:2] + 8'(k)]);
    rd(ADR_FRAME_SP, base, "frame sp");
    wb(1'b0, ADR_PEND, 32'h0, q);
    chk("pending", 32'h0, 32'(q[num]));
    wb(1'b0, ADR_ACTIVE, 32'h0, q);
    chk("active", 32'h1, 32'(q[num]));
    exception_number_status_i <= 9'(num);
    spsel_i <= 1'b0;
    cur_prio_i <= pr;
  endtask : enter

  task automatic t_regs();
    logic [31:0] q;
    rd(ADR_CTRL, 32'h0, "control reset");
    rd(ADR_VTOR, VTOR_RESET, "vector base reset");
    wb(1'b1, 8'h40, 32'hFFFF_FFFF, q);
    rd(8'h40, 32'h0, "unmapped");
    wb(1'b1, ADR_CTRL, 32'h2, q);
    rd(ADR_CTRL, 32'h2, "control split");
    wb(1'b1, ADR_CTRL, 32'h0, q);
    $display("test registers done");
  endtask : t_regs

  task automatic t_entries();
    logic [31:0] b, q;
    spsel_i <= 1'b1;
    enter(16, 8'h40, 1'b0, 32'h300, 1'b1, 1'b0, 8, b);
    exc_prio_i[17] <= 8'h40;
    exc_set_i[17] <= 1'b1;
    repeat (20) begin
      @(posedge clk_i);
      exc_set_i <= '0;
      chk("busy", 32'h0, 32'(busy_o));
    end
    wb(1'b0, ADR_PEND, 32'h0, q);
    chk("pending set", 32'h1, 32'(q[17]));
    exc_prio_i[17] <= 8'hFF;
    // Split lowers a Non-secure priority below the current level
    wb(1'b1, ADR_CTRL, 32'h2, q);
    exc_prio_i[18] <= 8'h20;
    exc_set_i[18] <= 1'b1;
    repeat (20) begin
      @(posedge clk_i);
      exc_set_i <= '0;
      chk("busy split", 32'h0, 32'(busy_o));
    end
    exc_prio_i[18] <= 8'hFF;
    wb(1'b1, ADR_CTRL, 32'h0, q);
    spsel_i <= 1'b1;
    mem_wait <= 4'h3;
    enter(6, 8'h20, 1'b1, 32'h304, 1'b0, 1'b1, 25, b);
    for (int i = 0; i < 17; i++)
      chk("fp word", {27'h7800000, 5'(i)}, u_mem.mem[b[9:2] + 8'(8 + i)]);
    wb(1'b1, ADR_CTRL, 32'h1, q);
    mem_wait <= 4'h1;
    enter(11, 8'h10, 1'b1, 32'h300, 1'b1, 1'b1, 8, b);
    wb(1'b0, ADR_STATUS, 32'h0, q);
    chk("lazy active", 32'h1, 32'(q[ST_LAZY_BIT]));
    rd(ADR_FP_ADDR, b + 32'h20, "lazy area");
    wb(1'b1, ADR_CTRL, 32'h0, q);
    $display("test entries done");
  endtask : t_entries

  task automatic fnc(input logic [31:0] pl, input logic [4:0] e);
    logic [31:0] q;
    pc_load_i <= pl;
    fnc_chk_i <= 1'b1;
    @(posedge clk_i);
    fnc_chk_i <= 1'b0;
    wb(1'b0, ADR_STATUS, 32'h0, q);
    chk("fault status", 32'(e), 32'(q[4:0]));
    wb(1'b1, ADR_STATUS, 32'h1F, q);
  endtask : fnc

  task automatic t_fnc();
    logic [31:0] q;
    exception_number_status_i <= 9'h1;
    stacked_exception_number_status_i <= 9'h5;
    stacked_ra_i <= 32'h2001;
    fnc(32'h1234_5679, 5'h0);
    fnc({FNC_RET_UPPER, 1'b1}, 5'h1);
    wb(1'b0, ADR_PEND, 32'h0, q);
    chk("usage pending", 32'h1, 32'(q[USAGE_FAULT_NUM]));
    ret_handler_i <= 1'b1;
    stacked_ra_i <= 32'h2000;
    fnc({FNC_RET_UPPER, 1'b0}, 5'h2);
    $display("test function return done");
  endtask : t_fnc

  initial begin
    err_total = 0;
    checks = 0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, fnc_chk_i, ret_handler_i} = 5'h0;
    {vec_secure_i, vec_sg_nsc_i, spsel_i, sfpa_i, fpca_i} = 5'h0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    mem_wait = 4'h0;
    for (int i = 0; i < 13; i++)
      regs_i[i] = 32'hA000_0000 + 32'(i);
    lr_i = 32'hB000_00E1;
    sp_i = 32'h300;
    psr_i = 32'h0;
    exception_number_status_i = 9'h0;
    cur_pc_i = 32'h2341;
    next_pc_i = 32'h2345;
    cur_prio_i = 8'h80;
    {exc_set_i, exc_sync_i, exc_secure_i} = '0;
    exc_prio_i = '1;
    pc_load_i = 32'h0;
    stacked_exception_number_status_i = 9'h0;
    stacked_ra_i = 32'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_entries();
    t_fnc();
    final_report();
  end

  initial begin
    #100us;
    err_total++;
    final_report();
  end
endmodule : test_exception_entry_stacking
